// File: core/rpm_power_modes.sv
// Behaviour
// - The block is only a serial slave and drives nothing on the link unless the host selects it.
// - Besides the serial lines there is an attention request out and a wake request in.
// - The block is always in exactly one of three power modes: active, idle or deep sleep.
// - In active mode every function runs, nothing gated or halted.
// - In idle mode instruction execution halts and resumes on any interrupt.
// - In idle mode all peripherals, the radio included, stay clocked.
// - In deep sleep most functions are off but the pad supply domain stays powered.
// - Deep sleep ends on a sleep-timer expiry, an external interrupt or a debug port command.
module rpm_power_modes
  import rpm_pkg::*;
#(
  parameter int unsigned AMP_SETTLE_CYC = AMP_SETTLE_CYC_DEF
) (
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire logic                i_spi_sclk,
  input  wire logic                i_spi_mosi,
  input  wire logic                i_spi_ssel_n,
  output logic                     o_spi_miso,
  output logic                     o_host_attention_request_n,
  input  wire logic                i_wake_request_n,
  input  wire logic                i_amp_bias_enable,
  output logic                     o_amp_ready,
  input  wire logic                i_sleep_req,
  input  wire logic                i_idle_req,
  input  wire logic                i_irq,
  input  wire logic                i_ext_irq_n,
  input  wire logic                i_debug_access_port_cmd,
  input  wire logic                i_sleep_timer_en,
  input  wire logic [PERIOD_W-1:0] i_sleep_period,
  input  wire logic                i_attn_req,
  input  wire logic [BYTE_W-1:0]   i_tx_byte,
  output logic [BYTE_W-1:0]        o_rx_byte,
  output logic                     o_rx_valid,
  output logic [1:0]               o_power_mode,
  output logic                     o_cpu_halt,
  output logic                     o_periph_clk_en,
  output logic                     o_core_power_en,
  output logic                     o_pad_supply_domain_on,
  output logic [1:0]               o_wake_cause
);

  rpm_mode_t            mode_q;
  rpm_mode_t            mode_d;
  rpm_wake_t            cause_q;
  rpm_wake_t            cause_d;
  logic                 timer_fire;
  logic                 ext_wake;
  logic                 wake_any;
  logic                 sclk_q;
  logic                 ssel_n_q;
  logic                 wake_n_q;
  logic                 sclk_rise;
  logic                 sclk_fall;
  logic                 ssel_fall;
  logic                 wake_fall;
  logic                 link_on;
  logic [BIT_CNT_W-1:0] bit_q;
  logic [BYTE_W-1:0]    rx_sh_q;
  logic [BYTE_W-1:0]    tx_sh_q;
  logic [BYTE_W-1:0]    tx_d;
  logic                 miso_q;
  logic                 attn_q;
  logic [SETTLE_W-1:0]  settle_q;

  rpm_sleep_timer u_sleep_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_run     (mode_q == RPM_DEEP),
    .i_enable  (i_sleep_timer_en),
    .i_period  (i_sleep_period),
    .o_fire    (timer_fire)
  );

  // Wake request from the host counts as an external interrupt
  assign ext_wake = !i_ext_irq_n || !i_wake_request_n;
  assign wake_any = timer_fire || ext_wake || i_debug_access_port_cmd;

  always_comb begin
    mode_d  = mode_q;
    cause_d = cause_q;
    unique case (mode_q)
      RPM_ACTIVE: begin
        if (i_sleep_req) begin
          mode_d = RPM_DEEP;
        end else if (i_idle_req) begin
          mode_d = RPM_IDLE;
        end
      end
      RPM_IDLE: begin
        if (i_irq || wake_any) begin
          mode_d = RPM_ACTIVE;
        end
      end
      RPM_DEEP: begin
        if (wake_any) begin
          mode_d = RPM_ACTIVE;
          if (timer_fire) begin
            cause_d = RPM_WAKE_TIMER;
          end else if (ext_wake) begin
            cause_d = RPM_WAKE_EXT;
          end else begin
            cause_d = RPM_WAKE_DEBUG;
          end
        end
      end
      default: begin
        mode_d = RPM_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mode_q  <= RPM_ACTIVE;
      cause_q <= RPM_WAKE_NONE;
    end else begin
      mode_q  <= mode_d;
      cause_q <= cause_d;
    end
  end

  assign o_power_mode           = mode_q;
  assign o_wake_cause           = cause_q;
  assign o_cpu_halt             = (mode_q != RPM_ACTIVE);
  assign o_periph_clk_en        = (mode_q != RPM_DEEP);
  assign o_core_power_en        = (mode_q != RPM_DEEP);
  assign o_pad_supply_domain_on = 1'b1;

  // Serial slave, mode 0, off while in deep sleep
  assign link_on   = (mode_q != RPM_DEEP) && !i_spi_ssel_n;
  assign sclk_rise = rpm_rose(sclk_q, i_spi_sclk);
  assign sclk_fall = rpm_fell(sclk_q, i_spi_sclk);
  assign ssel_fall = rpm_fell(ssel_n_q, i_spi_ssel_n);
  assign wake_fall = rpm_fell(wake_n_q, i_wake_request_n);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sclk_q   <= 1'b0;
      ssel_n_q <= 1'b1;
      wake_n_q <= 1'b1;
    end else begin
      sclk_q   <= i_spi_sclk;
      ssel_n_q <= i_spi_ssel_n;
      wake_n_q <= i_wake_request_n;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !link_on) begin
      bit_q      <= BIT_RST;
      rx_sh_q    <= BYTE_RST;
      o_rx_byte  <= BYTE_RST;
      o_rx_valid <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      if (sclk_rise) begin
        bit_q   <= bit_q + BIT_ONE;
        rx_sh_q <= {rx_sh_q[BYTE_W-2:0], i_spi_mosi};
        if (bit_q == ~BIT_RST) begin
          o_rx_byte  <= {rx_sh_q[BYTE_W-2:0], i_spi_mosi};
          o_rx_valid <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    tx_d = tx_sh_q;
    if (ssel_fall || (sclk_fall && bit_q == BIT_RST)) begin
      tx_d = i_tx_byte;
    end else if (sclk_fall) begin
      tx_d = {tx_sh_q[BYTE_W-2:0], 1'b0};
    end
  end

  // Data out only while selected by the host
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !link_on) begin
      tx_sh_q <= BYTE_RST;
      miso_q  <= 1'b0;
    end else begin
      tx_sh_q <= tx_d;
      miso_q  <= tx_d[BYTE_W-1];
    end
  end

  assign o_spi_miso = miso_q;

  // Attention: set on wake or firmware request, set wins over host select
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      attn_q <= 1'b0;
    end else if (i_attn_req || (mode_q == RPM_DEEP && wake_any)
                 || (mode_q != RPM_DEEP && wake_fall)) begin
      attn_q <= 1'b1;
    end else if (ssel_fall) begin
      attn_q <= 1'b0;
    end
  end

  assign o_host_attention_request_n = ~attn_q;

  // Amplifier bias settle timer
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_amp_bias_enable) begin
      settle_q    <= SETTLE_RST;
      o_amp_ready <= 1'b0;
    end else if (settle_q == SETTLE_W'(AMP_SETTLE_CYC - 1)) begin
      o_amp_ready <= 1'b1;
    end else begin
      settle_q <= settle_q + SETTLE_ONE;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  miso_quiet_a: assert property (
    i_spi_ssel_n |=> !o_spi_miso)
    else $error("miso driven while deselected");

  attn_wake_a: assert property (
    (mode_q == RPM_DEEP && !i_wake_request_n && !timer_fire)
      |=> (!o_host_attention_request_n && mode_q == RPM_ACTIVE && cause_q == RPM_WAKE_EXT))
    else $error("wake request not answered by attention");

  mode_legal_a: assert property (
    mode_q inside {RPM_ACTIVE, RPM_IDLE, RPM_DEEP})
    else $error("illegal power mode");

  active_run_a: assert property (
    (mode_q == RPM_ACTIVE) |-> (!o_cpu_halt && o_periph_clk_en && o_core_power_en))
    else $error("active mode has something gated");

  idle_resume_a: assert property (
    (mode_q == RPM_IDLE && i_irq) |=> (mode_q == RPM_ACTIVE && !o_cpu_halt))
    else $error("idle did not resume on interrupt");

  idle_periph_a: assert property (
    (mode_q == RPM_IDLE) |-> (o_cpu_halt && o_periph_clk_en && o_core_power_en))
    else $error("idle mode stopped peripherals");

  pad_keep_a: assert property (
    (mode_q == RPM_DEEP) |-> (o_pad_supply_domain_on && !o_core_power_en && !o_periph_clk_en))
    else $error("deep sleep power state wrong");

  timer_wake_a: assert property (
    (mode_q == RPM_DEEP && timer_fire) |=> (mode_q == RPM_ACTIVE && cause_q == RPM_WAKE_TIMER))
    else $error("sleep timer did not wake");

  debug_wake_a: assert property (
    (mode_q == RPM_DEEP && i_debug_access_port_cmd && !timer_fire && !ext_wake)
      |=> (mode_q == RPM_ACTIVE && cause_q == RPM_WAKE_DEBUG))
    else $error("debug command did not wake");

  deep_stays_a: assert property (
    (mode_q == RPM_DEEP && !wake_any) |=> (mode_q == RPM_DEEP))
    else $error("left deep sleep without a wake event");

endmodule : rpm_power_modes

// File: core/rpm_pkg.sv
package rpm_pkg;

  typedef enum logic [1:0] {
    RPM_ACTIVE = 2'h0,
    RPM_IDLE   = 2'h1,
    RPM_DEEP   = 2'h2
  } rpm_mode_t;

  typedef enum logic [1:0] {
    RPM_WAKE_NONE  = 2'h0,
    RPM_WAKE_TIMER = 2'h1,
    RPM_WAKE_EXT   = 2'h2,
    RPM_WAKE_DEBUG = 2'h3
  } rpm_wake_t;

  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned SLEEP_TICK_NS  = 1000;
  localparam int unsigned SLEEP_TICK_CYC = (SLEEP_TICK_NS * 1000 + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
  localparam int unsigned AMP_SETTLE_US  = 250;
  localparam int unsigned AMP_SETTLE_CYC_DEF = (AMP_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;

  localparam int unsigned TICK_W    = 8;
  localparam int unsigned PERIOD_W  = 16;
  localparam int unsigned SETTLE_W  = 16;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned BIT_CNT_W = 3;

  localparam logic [TICK_W-1:0]    TICK_RST   = 8'h00;
  localparam logic [TICK_W-1:0]    TICK_LAST  = TICK_W'(SLEEP_TICK_CYC - 1);
  localparam logic [PERIOD_W-1:0]  PERIOD_RST = 16'h0000;
  localparam logic [PERIOD_W-1:0]  PERIOD_ONE = 16'h0001;
  localparam logic [SETTLE_W-1:0]  SETTLE_RST = 16'h0000;
  localparam logic [SETTLE_W-1:0]  SETTLE_ONE = 16'h0001;
  localparam logic [BYTE_W-1:0]    BYTE_RST   = 8'h00;
  localparam logic [BIT_CNT_W-1:0] BIT_RST    = 3'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_ONE    = 3'h1;

  function automatic logic rpm_rose(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction : rpm_rose

  function automatic logic rpm_fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction : rpm_fell

endpackage : rpm_pkg

// File: core/rpm_sleep_timer.sv
module rpm_sleep_timer
  import rpm_pkg::*;
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire logic                i_run,
  input  wire logic                i_enable,
  input  wire logic [PERIOD_W-1:0] i_period,
  output logic                     o_fire
);

  logic [TICK_W-1:0]   tick_q;
  logic [PERIOD_W-1:0] elapsed_q;
  logic                fired_q;
  logic                tick;
  logic                armed;

  assign armed = i_run && i_enable && (i_period != PERIOD_RST);
  assign tick  = armed && (tick_q == TICK_LAST);

  // One-microsecond tick divider
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !armed || tick) begin
      tick_q <= TICK_RST;
    end else begin
      tick_q <= tick_q + TICK_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !armed) begin
      elapsed_q <= PERIOD_RST;
    end else if (tick && !fired_q) begin
      elapsed_q <= elapsed_q + PERIOD_ONE;
    end
  end

  // Single pulse per sleep period
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !armed) begin
      fired_q <= 1'b0;
      o_fire  <= 1'b0;
    end else begin
      o_fire <= tick && !fired_q && (elapsed_q + PERIOD_ONE == i_period);
      if (tick && !fired_q && (elapsed_q + PERIOD_ONE == i_period)) begin
        fired_q <= 1'b1;
      end
    end
  end

endmodule : rpm_sleep_timer

// File: sim/rpm_host_model.sv
module rpm_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_miso,
  input  wire logic i_attn_n,
  output logic      o_sclk,
  output logic      o_mosi,
  output logic      o_ssel_n,
  output logic      o_wake_n,
  output logic      o_amp_en
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_sclk   = 1'b0;
    o_mosi   = 1'b1;
    o_ssel_n = 1'b1;
    o_wake_n = 1'b1;
    o_amp_en = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : hold

  // Bias follows sleep; wait out the settle time after raising
  task automatic amp_set(input logic en, input int settle);
    o_amp_en = en;
    hold(settle);
  endtask : amp_set

  task automatic wake(output logic ok);
    int n;
    n = 0;
    o_wake_n = 1'b0;
    while (i_attn_n !== 1'b0 && n < 2000) begin
      hold(1);
      n++;
    end
    o_wake_n = 1'b1;
    ok = (i_attn_n === 1'b0);
  endtask : wake

  // Host starts every frame; mode 0, MSB first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    o_ssel_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      o_mosi = tx[i];
      hold(3);
      rx[i] = i_miso;
      o_sclk = 1'b1;
      hold(2);
      o_sclk = 1'b0;
    end
    hold(3);
    o_ssel_n = 1'b1;
    o_mosi   = ~o_mosi;
  endtask : xfer
endmodule : rpm_host_model

// File: sim/tb_top.sv
module tb_top
  import rpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned SETTLE = 20;
  localparam int          LIMIT  = 20000;

  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                sclk, mosi, ssel_n, wake_n, amp_en;
  logic                miso, attn_n, amp_rdy, rxv;
  logic                slp = 1'b0;
  logic                idl = 1'b0;
  logic                irq = 1'b0;
  logic                ext_n = 1'b1;
  logic                dbg = 1'b0;
  logic                ten = 1'b0;
  logic                areq = 1'b0;
  logic [PERIOD_W-1:0] per = 16'h0000;
  logic [BYTE_W-1:0]   txb = 8'h00;
  logic [BYTE_W-1:0]   rxb, rxs;
  logic [1:0]          mode, cause;
  logic                halt, pclk, core, pad;
  int                  failures = 0;
  int                  checks_done = 0;
  int                  cyc = 0;

  always #2 clk = ~clk;

  rpm_host_model host (.i_sys_clk(clk), .i_miso(miso), .i_attn_n(attn_n), .o_sclk(sclk),
    .o_mosi(mosi), .o_ssel_n(ssel_n), .o_wake_n(wake_n), .o_amp_en(amp_en));

  rpm_power_modes #(.AMP_SETTLE_CYC(SETTLE)) uut (.i_sys_clk(clk), .i_rst(rst),
    .i_spi_sclk(sclk), .i_spi_mosi(mosi), .i_spi_ssel_n(ssel_n), .o_spi_miso(miso),
    .o_host_attention_request_n(attn_n), .i_wake_request_n(wake_n),
    .i_amp_bias_enable(amp_en), .o_amp_ready(amp_rdy), .i_sleep_req(slp),
    .i_idle_req(idl), .i_irq(irq), .i_ext_irq_n(ext_n), .i_debug_access_port_cmd(dbg),
    .i_sleep_timer_en(ten), .i_sleep_period(per), .i_attn_req(areq), .i_tx_byte(txb),
    .o_rx_byte(rxb), .o_rx_valid(rxv), .o_power_mode(mode), .o_cpu_halt(halt),
    .o_periph_clk_en(pclk), .o_core_power_en(core), .o_pad_supply_domain_on(pad),
    .o_wake_cause(cause));

  always @(posedge clk) if (rxv === 1'b1) rxs <= rxb;

  task automatic final_report;
    $display("Checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic wait_mode(input logic [1:0] m);
    int n;
    n = 0;
    while (mode !== m && n < 600) begin
      step(1);
      n++;
    end
    chk(mode, m, "mode");
  endtask : wait_mode

  task automatic t_reset;
    chk(mode, RPM_ACTIVE, "reset mode");
    chk(cause, RPM_WAKE_NONE, "reset cause");
    chk({halt, pclk, core, pad}, 4'h7, "active gates");
    chk(attn_n, 1'b1, "reset attn");
  endtask : t_reset

  task automatic t_idle;
    idl = 1'b1;
    step(2);
    idl = 1'b0;
    chk(mode, RPM_IDLE, "idle mode");
    chk({halt, pclk, core}, 3'h7, "idle gates");
    irq = 1'b1;
    step(2);
    irq = 1'b0;
    chk({mode, halt}, {RPM_ACTIVE, 1'b0}, "idle exit");
  endtask : t_idle

  task automatic t_deep(input logic [1:0] src);
    logic [7:0] rx;
    host.xfer(8'h00, rx);
    chk(attn_n, 1'b1, "attn cleared");
    host.amp_set(1'b0, 2);
    chk(amp_rdy, 1'b0, "amp off");
    slp = 1'b1;
    idl = 1'b1;
    step(1);
    slp = 1'b0;
    idl = 1'b0;
    chk(mode, RPM_DEEP, "deep mode");
    chk({halt, pclk, core, pad}, 4'h9, "deep gates");
    per = 16'h0001;
    ten = (src == RPM_WAKE_TIMER);
    ext_n = (src != RPM_WAKE_EXT);
    dbg = (src == RPM_WAKE_DEBUG);
    wait_mode(RPM_ACTIVE);
    ten = 1'b0;
    ext_n = 1'b1;
    dbg = 1'b0;
    step(1);
    chk({cause, attn_n}, {src, 1'b0}, "cause");
    host.amp_set(1'b1, SETTLE - 1);
    chk(amp_rdy, 1'b0, "amp early");
    step(1);
    chk(amp_rdy, 1'b1, "amp ready");
  endtask : t_deep

  task automatic t_spi;
    logic [7:0] rx;
    logic       ok;
    txb = 8'h3C;
    host.xfer(8'hA5, rx);
    chk(rx, 8'h3C, "miso");
    chk(rxs, 8'hA5, "rx");
    chk(attn_n, 1'b1, "attn select clear");
    areq = 1'b1;
    step(1);
    areq = 1'b0;
    step(1);
    chk(attn_n, 1'b0, "attn req");
    txb = 8'hC3;
    host.xfer(8'h5A, rx);
    chk(rx, 8'hC3, "second miso");
    chk(rxs, 8'h5A, "second byte");
    host.wake(ok);
    chk(ok, 1'b1, "wake");
  endtask : t_spi

  // Host wake line pulls the block out of deep sleep
  task automatic t_host_wake;
    logic [7:0] rx;
    logic       ok;
    host.xfer(8'h00, rx);
    chk(attn_n, 1'b1, "attn before sleep");
    host.amp_set(1'b0, 2);
    slp = 1'b1;
    step(1);
    slp = 1'b0;
    chk(mode, RPM_DEEP, "deep before wake");
    host.wake(ok);
    chk({ok, mode, cause}, {1'b1, RPM_ACTIVE, RPM_WAKE_EXT}, "host wake");
    host.amp_set(1'b1, SETTLE);
    chk(amp_rdy, 1'b1, "amp back");
  endtask : t_host_wake

  initial begin
    step(8);
    rst = 1'b0;
    step(1);
    t_reset();
    t_idle();
    t_deep(RPM_WAKE_TIMER);
    t_deep(RPM_WAKE_EXT);
    t_deep(RPM_WAKE_DEBUG);
    t_spi();
    t_host_wake();
    final_report();
  end
endmodule : tb_top
